/* File: common/uesr_pkg.sv */
`default_nettype none
package uesr_pkg;
   // Register byte offsets
   localparam logic [7:0] UESR_OFF_ENABLE = 8'h00;
   localparam logic [7:0] UESR_OFF_FIFO_LO = 8'h04;
   localparam logic [7:0] UESR_OFF_FIFO_HI = 8'h08;
   localparam logic [7:0] UESR_OFF_STATUS = 8'h0c;
   localparam logic [7:0] UESR_OFF_SENT = 8'h10;
   localparam logic [7:0] UESR_OFF_LAST_SENSE = 8'h14;
   localparam logic [7:0] UESR_OFF_LAST_INFO = 8'h18;
   // Status, sense keys, codes and qualifiers
   localparam logic [7:0] UESR_STAT_CHECK = 8'h02;
   localparam logic [7:0] UESR_KEY_NOT_READY = 8'h02;
   localparam logic [7:0] UESR_KEY_UNIT_ATTN = 8'h06;
   localparam logic [7:0] UESR_CODE_NOT_READY = 8'h04;
   localparam logic [7:0] UESR_CODE_MEDIUM_CHG = 8'h28;
   localparam logic [7:0] UESR_CODE_RESET = 8'h29;
   localparam logic [7:0] UESR_CODE_ESN = 8'h7f;
   localparam logic [7:0] UESR_QUAL_NONE = 8'h00;
   localparam logic [7:0] UESR_QUAL_POWER = 8'h02;
   localparam logic [7:0] UESR_QUAL_MEDIA = 8'h04;
   localparam logic [7:0] UESR_QUAL_BUSY = 8'h06;
   // Event and status byte codes
   localparam logic [7:0] UESR_PM_EVT_NONE = 8'h00;
   localparam logic [7:0] UESR_PM_EVT_ENTERED = 8'h01;
   localparam logic [7:0] UESR_PM_EVT_FAILED = 8'h02;
   localparam logic [7:0] UESR_PM_ST_ACTIVE = 8'h01;
   localparam logic [7:0] UESR_PM_ST_IDLE = 8'h02;
   localparam logic [7:0] UESR_PM_ST_STANDBY = 8'h03;
   localparam logic [7:0] UESR_MD_EVT_NONE = 8'h00;
   localparam logic [7:0] UESR_MD_EVT_EJECT = 8'h01;
   localparam logic [7:0] UESR_MD_EVT_NEW = 8'h02;
   localparam logic [7:0] UESR_MD_EVT_REMOVED = 8'h03;
   localparam int UESR_BUSY_UNIT_MS = 100;
   // Pending bit positions, in priority order
   localparam int UESR_NPEND = 7;
   localparam int UESR_P_RESET = 0;
   localparam int UESR_P_NOTRDY = 1;
   localparam int UESR_P_READY = 2;
   localparam int UESR_P_DEFER = 3;
   localparam int UESR_P_BUSY = 4;
   localparam int UESR_P_MEDIA = 5;
   localparam int UESR_P_POWER = 6;
   // Status register fields
   localparam int UESR_ST_OVR_LSB = 8;
   localparam int UESR_ST_ARMED = 16;
   localparam int UESR_ST_SENDING = 17;
   // Reset values
   localparam logic [6:0] UESR_PEND_RST = 7'h01;
   localparam logic [47:0] UESR_FIFO_RST = 48'h0;
   // Information field, byte 0 in the top bits
   typedef struct packed {
      logic [7:0] event_code;
      logic [7:0] status_code;
      logic [7:0] spec_hi;
      logic [7:0] spec_lo;
   } uesr_info_type;
   // One status block
   typedef struct packed {
      logic [7:0] status;
      logic [7:0] sense_key;
      logic [7:0] sense_code;
      logic [7:0] qualifier;
      uesr_info_type info;
   } uesr_blk_type;
   typedef enum logic [1:0] {
      UESR_IDLE = 2'b00,
      UESR_SEND = 2'b01,
      UESR_DONE = 2'b11
   } uesr_state_type;
endpackage : uesr_pkg
`default_nettype wire

/* File: core/uesr_sender.sv */
`timescale 1ns/1ps
`default_nettype none
module uesr_sender
   import uesr_pkg::*;
#(
   parameter int ADDR_W = 48
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load,
   input wire uesr_blk_type blk_in,
   input wire logic [ADDR_W-1:0] addr_in,
   output logic blk_valid,
   input wire logic blk_ready,
   output uesr_blk_type blk_data,
   output logic [ADDR_W-1:0] blk_addr,
   output logic done
);
   logic valid_q, valid_d;
   uesr_blk_type data_q, data_d;
   logic [ADDR_W-1:0] addr_q, addr_d;

   // Hold one block until the link takes it
   always_comb begin
      valid_d = valid_q;
      data_d = data_q;
      addr_d = addr_q;
      if (valid_q && blk_ready) begin
         valid_d = 1'b0;
      end
      if (load && !valid_q) begin
         valid_d = 1'b1;
         data_d = blk_in;
         addr_d = addr_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= 1'b0;
         data_q <= '0;
         addr_q <= '0;
      end else begin
         valid_q <= valid_d;
         data_q <= data_d;
         addr_q <= addr_d;
      end
   end

   assign blk_valid = valid_q;
   assign blk_data = data_q;
   assign blk_addr = addr_q;
   assign done = valid_q && blk_ready;
endmodule : uesr_sender
`default_nettype wire

/* File: core/uesr_reporter.sv */
`timescale 1ns/1ps
`default_nettype none
module uesr_reporter
   import uesr_pkg::*;
#(
   parameter int PADDR_W = 8,
   parameter int ADDR_W = 48
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic dev_ready,
   input wire logic bus_reset,
   input wire logic defer_valid,
   input wire uesr_blk_type defer_blk,
   input wire logic power_valid,
   input wire uesr_info_type power_info,
   input wire logic media_valid,
   input wire uesr_info_type media_info,
   input wire logic busy_valid,
   input wire logic [7:0] busy_event,
   input wire logic [7:0] busy_status,
   input wire logic [15:0] busy_time,
   output logic blk_valid,
   input wire logic blk_ready,
   output uesr_blk_type blk_data,
   output logic [ADDR_W-1:0] blk_addr
);
   // Lowest set pending bit wins
   function automatic logic [2:0] pick(input logic [UESR_NPEND-1:0] p);
      logic [2:0] idx;
      idx = 3'd0;
      for (int i = UESR_NPEND - 1; i >= 0; i--) begin
         if (p[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : pick

   // Fixed header for a sense block
   function automatic uesr_blk_type head(input logic [7:0] key,
                                         input logic [7:0] code,
                                         input logic [7:0] qual);
      uesr_blk_type b;
      b = '0;
      b.status = UESR_STAT_CHECK;
      b.sense_key = key;
      b.sense_code = code;
      b.qualifier = qual;
      return b;
   endfunction : head

   // Event status notification block of one class
   function automatic uesr_blk_type esn(input logic [7:0] qual,
                                        input uesr_info_type inf);
      uesr_blk_type b;
      b = head(UESR_KEY_UNIT_ATTN, UESR_CODE_ESN, qual);
      b.info = inf;
      return b;
   endfunction : esn

   // Register address match, offset sized to the bus
   // Keeps every decode and write strobe on one comparison
   function automatic logic addr_is(input logic [PADDR_W-1:0] a, input logic [7:0] off);
      return a == PADDR_W'(off);
   endfunction : addr_is

   logic apb_wr, apb_rd_ok, hit;
   logic sending, done;
   uesr_state_type state_q, state_d;
   logic armed_q, armed_d;
   logic init_q, init_d;
   logic rdy_q, rdy_d;
   logic [UESR_NPEND-1:0] pend_q, pend_d;
   logic [UESR_NPEND-1:0] ovr_q, ovr_d;
   logic [UESR_NPEND-1:0] set_v, clr_v;
   logic [2:0] sel_q, sel_d;
   logic [ADDR_W-1:0] fifo_q, fifo_d;
   logic [15:0] sent_q, sent_d;
   uesr_blk_type last_q, last_d;
   uesr_blk_type defer_q, defer_d;
   uesr_info_type power_q, power_d;
   uesr_info_type media_q, media_d;
   uesr_info_type busy_q, busy_d;
   uesr_blk_type build;
   logic [31:0] rdata;
   // Registered read word toward the bus
   logic [31:0] rd_q, rd_d;
   logic load;

   // APB strobes; the slave never waits
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd_ok = psel && !penable && !pwrite; // Setup cycle of a read
   assign pready = 1'b1;

   // Address decode
   always_comb begin
      hit = 1'b1;
      rdata = 32'h0;
      if (addr_is(paddr, UESR_OFF_ENABLE)) begin
         rdata[0] = armed_q;
      end else if (addr_is(paddr, UESR_OFF_FIFO_LO)) begin
         rdata = fifo_q[31:0];
      end else if (addr_is(paddr, UESR_OFF_FIFO_HI)) begin
         rdata[ADDR_W-33:0] = fifo_q[ADDR_W-1:32];
      end else if (addr_is(paddr, UESR_OFF_STATUS)) begin
         rdata[UESR_NPEND-1:0] = pend_q;
         rdata[UESR_ST_OVR_LSB +: UESR_NPEND] = ovr_q;
         rdata[UESR_ST_ARMED] = armed_q;
         rdata[UESR_ST_SENDING] = sending;
      end else if (addr_is(paddr, UESR_OFF_SENT)) begin
         rdata[15:0] = sent_q;
      end else if (addr_is(paddr, UESR_OFF_LAST_SENSE)) begin
         rdata = {last_q.status, last_q.sense_key, last_q.sense_code, last_q.qualifier};
      end else if (addr_is(paddr, UESR_OFF_LAST_INFO)) begin
         rdata = last_q.info;
      end else begin
         hit = 1'b0;
      end
   end

   // Read word taken in the setup cycle, zero otherwise
   // The access phase then shows a flop, so pready can stay high
   always_comb begin
      rd_d = 32'h0;
      if (apb_rd_ok && hit) begin
         rd_d = rdata;
      end
   end

   // Read word flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 32'h0;
      end else begin
         rd_q <= rd_d;
      end
   end

   // Read data from the flop and error answer
   assign prdata = rd_q;
   assign pslverr = psel && penable && !hit;

   // Login address register
   always_comb begin
      fifo_d = fifo_q;
      if (apb_wr && addr_is(paddr, UESR_OFF_FIFO_LO)) begin
         fifo_d[31:0] = pwdata;
      end
      if (apb_wr && addr_is(paddr, UESR_OFF_FIFO_HI)) begin
         fifo_d[ADDR_W-1:32] = pwdata[ADDR_W-33:0];
      end
   end

   // Event detection into set vector
   always_comb begin
      init_d = 1'b0;
      rdy_d = dev_ready;
      set_v = '0;
      if (init_q && !dev_ready) begin
         set_v[UESR_P_NOTRDY] = 1'b1;
      end
      if (!init_q && rdy_q && !dev_ready) begin
         set_v[UESR_P_NOTRDY] = 1'b1;
      end
      if (!init_q && !rdy_q && dev_ready) begin
         set_v[UESR_P_READY] = 1'b1;
      end
      set_v[UESR_P_RESET] = bus_reset;
      set_v[UESR_P_DEFER] = defer_valid;
      set_v[UESR_P_BUSY] = busy_valid;
      set_v[UESR_P_MEDIA] = media_valid;
      set_v[UESR_P_POWER] = power_valid;
   end

   // Latest payload of each class
   always_comb begin
      defer_d = defer_valid ? defer_blk : defer_q;
      power_d = power_valid ? power_info : power_q;
      media_d = media_valid ? media_info : media_q;
      busy_d = busy_q;
      if (busy_valid) begin
         busy_d.event_code = busy_event;
         busy_d.status_code = busy_status;
         busy_d.spec_hi = busy_time[15:8];
         busy_d.spec_lo = busy_time[7:0];
      end
   end

   // Block for the selected pending class
   always_comb begin
      case (sel_d)
         3'(UESR_P_RESET): build = head(UESR_KEY_UNIT_ATTN, UESR_CODE_RESET, UESR_QUAL_NONE);
         3'(UESR_P_NOTRDY): build = head(UESR_KEY_NOT_READY, UESR_CODE_NOT_READY, UESR_QUAL_NONE);
         3'(UESR_P_READY): build = head(UESR_KEY_UNIT_ATTN, UESR_CODE_MEDIUM_CHG, UESR_QUAL_NONE);
         3'(UESR_P_DEFER): build = defer_q;
         3'(UESR_P_BUSY): build = esn(UESR_QUAL_BUSY, busy_q);
         3'(UESR_P_MEDIA): build = esn(UESR_QUAL_MEDIA, media_q);
         default: build = esn(UESR_QUAL_POWER, power_q);
      endcase
   end

   // Report sequencer; events are pushed, never polled
   always_comb begin
      state_d = state_q;
      sel_d = sel_q;
      load = 1'b0;
      clr_v = '0;
      armed_d = armed_q;
      sent_d = sent_q;
      last_d = last_q;
      case (state_q)
         UESR_IDLE: begin
            sel_d = pick(pend_q);
            if (armed_q && |pend_q) begin
               load = 1'b1;
               state_d = UESR_SEND;
            end
         end
         UESR_SEND: begin
            if (done) begin
               clr_v[sel_q] = 1'b1;
               armed_d = 1'b0;
               sent_d = sent_q + 16'h1;
               last_d = blk_data;
               state_d = UESR_DONE;
            end
         end
         default: begin
            state_d = UESR_IDLE;
         end
      endcase
      if (apb_wr && addr_is(paddr, UESR_OFF_ENABLE)) begin
         armed_d = 1'b1;
      end
   end

   // Pending and overrun flags; a new event beats a clear
   always_comb begin
      pend_d = (pend_q & ~clr_v) | set_v;
      ovr_d = ovr_q;
      if (apb_wr && addr_is(paddr, UESR_OFF_STATUS)) begin
         ovr_d = ovr_q & ~pwdata[UESR_ST_OVR_LSB +: UESR_NPEND];
      end
      ovr_d = ovr_d | (set_v & pend_q & ~clr_v);
   end

   // Busy while a block is in flight or just delivered
   assign sending = state_q != UESR_IDLE;

   // Login address flops
   // A change here only aims blocks loaded afterwards
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_q <= UESR_FIFO_RST;
      end else begin
         fifo_q <= fifo_d;
      end
   end

   // Ready edge detector flops
   // Init marks the first cycle after reset, so a device that wakes not ready still reports it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_q <= 1'b1;
         rdy_q <= 1'b1;
      end else begin
         init_q <= init_d;
         rdy_q <= rdy_d;
      end
   end

   // Payload flops
   // A newer event of a class replaces an unsent payload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         defer_q <= '0;
         power_q <= '0;
         media_q <= '0;
         busy_q <= '0;
      end else begin
         defer_q <= defer_d;
         power_q <= power_d;
         media_q <= media_d;
         busy_q <= busy_d;
      end
   end

   // Sequencer flops
   // Reset leaves reporting disarmed until software writes the enable register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= UESR_IDLE;
         sel_q <= 3'd0;
         armed_q <= 1'b0;
         sent_q <= 16'h0;
         last_q <= '0;
      end else begin
         state_q <= state_d;
         sel_q <= sel_d;
         armed_q <= armed_d;
         sent_q <= sent_d;
         last_q <= last_d;
      end
   end

   // Pending and overrun flops
   // Reset leaves the reset event pending
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= UESR_PEND_RST;
         ovr_q <= '0;
      end else begin
         pend_q <= pend_d;
         ovr_q <= ovr_d;
      end
   end

   // Block holding register toward the link
   uesr_sender #(
      .ADDR_W(ADDR_W)
   ) u_sender (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .blk_in(build),
      .addr_in(fifo_q),
      .blk_valid(blk_valid),
      .blk_ready(blk_ready),
      .blk_data(blk_data),
      .blk_addr(blk_addr),
      .done(done)
   );
endmodule : uesr_reporter
`default_nettype wire

/* File: sim/uesr_reporter_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module uesr_reporter_chk
   import uesr_pkg::*;
#(
   parameter int PADDR_W = 8,
   parameter int ADDR_W = 48
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic bus_reset,
   input wire logic defer_valid,
   input wire logic power_valid,
   input wire logic media_valid,
   input wire logic busy_valid,
   input wire logic blk_valid,
   input wire logic blk_ready,
   input wire uesr_blk_type blk_data,
   input wire logic [ADDR_W-1:0] blk_addr
);
   logic wr, armed_q, armed_d;
   logic [ADDR_W-1:0] fifo_q, fifo_d;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of arming and of the status FIFO address
   always_comb begin
      wr = psel && penable && pwrite && pready;
      armed_d = armed_q;
      fifo_d = fifo_q;
      if (blk_valid && blk_ready) begin
         armed_d = 1'b0;
      end
      if (wr && paddr == PADDR_W'(UESR_OFF_ENABLE)) begin
         armed_d = 1'b1;
      end
      if (wr && paddr == PADDR_W'(UESR_OFF_FIFO_LO)) begin
         fifo_d[31:0] = pwdata;
      end
      if (wr && paddr == PADDR_W'(UESR_OFF_FIFO_HI)) begin
         fifo_d[ADDR_W-1:32] = pwdata[ADDR_W-33:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= 1'b0;
         fifo_q <= '0;
      end else begin
         armed_q <= armed_d;
         fifo_q <= fifo_d;
      end
   end
   // Event seen while armed and idle, then a block offered soon
   sequence s_evt;
      (power_valid || media_valid || busy_valid || defer_valid || bus_reset) && armed_q && !blk_valid;
   endsequence
   sequence s_send;
      ##[1:3] blk_valid;
   endsequence
   a_no_unarmed_send: assert property (blk_valid |-> armed_q)
      else $error("block offered while not armed");
   a_notrdy_sense: assert property (blk_valid && blk_data.sense_key == 8'h02 |-> blk_data.sense_code == 8'h04)
      else $error("not ready key with wrong code");
   a_ua_codes: assert property (blk_valid && blk_data.sense_key == 8'h06 |->
      blk_data.sense_code inside {8'h28, 8'h29, 8'h7f})
      else $error("unit attention with unknown code");
   a_esn_header: assert property (blk_valid && blk_data.sense_code == 8'h7f |->
      blk_data.status == 8'h02 && blk_data.sense_key == 8'h06)
      else $error("event block header wrong");
   a_esn_class: assert property (blk_valid && blk_data.sense_code == 8'h7f |->
      blk_data.qualifier inside {8'h02, 8'h04, 8'h06})
      else $error("event block class wrong");
   a_fifo_target: assert property (blk_valid |-> blk_addr == fifo_q)
      else $error("block aimed at wrong address");
   a_one_per_arm: assert property (blk_valid && blk_ready |=> !blk_valid [*2])
      else $error("second block without new arming");
   a_prompt_send: assert property (s_evt |-> s_send)
      else $error("event not sent promptly");
endmodule : uesr_reporter_chk
bind uesr_reporter uesr_reporter_chk #(.PADDR_W(PADDR_W), .ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .pready(pready), .bus_reset(bus_reset), .defer_valid(defer_valid), .power_valid(power_valid),
   .media_valid(media_valid), .busy_valid(busy_valid), .blk_valid(blk_valid), .blk_ready(blk_ready),
   .blk_data(blk_data), .blk_addr(blk_addr));
`default_nettype wire

/* File: sim/uesr_fifo_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uesr_fifo_model
   import uesr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stall,
   input wire logic blk_valid,
   input wire uesr_blk_type blk_data,
   input wire logic [47:0] blk_addr,
   output logic blk_ready,
   output uesr_blk_type got_blk,
   output logic [47:0] got_addr,
   output logic [15:0] got_n
);
   // Takes a block on valid and ready, keeps it and its address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         blk_ready <= 1'b0;
         got_blk <= '0;
         got_addr <= 48'h0;
         got_n <= 16'h0000;
      end else begin
         blk_ready <= !stall;
         if (blk_valid && blk_ready) begin
            got_blk <= blk_data;
            got_addr <= blk_addr;
            got_n <= got_n + 16'h0001;
         end
      end
   end
endmodule : uesr_fifo_model
`default_nettype wire

/* File: sim/uesr_reporter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module uesr_reporter_tb
   import uesr_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dev_ready = 1'b1, stall = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, perr, blk_valid, blk_ready;
   logic [4:0] pv = 5'h00;
   uesr_blk_type defer_blk = '0, blk_data, got_blk;
   uesr_info_type power_info = '0, media_info = '0, inf;
   logic [31:0] busy_bits = 32'h0;
   logic [47:0] blk_addr, got_addr;
   logic [15:0] got_n;
   int n_errors = 0, n_tests = 0, cyc = 0, i;
   always #20 pclk = ~pclk;
   uesr_reporter #(.PADDR_W(8), .ADDR_W(48)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .dev_ready(dev_ready), .bus_reset(pv[4]), .defer_valid(pv[3]),
      .defer_blk(defer_blk), .power_valid(pv[0]), .power_info(power_info), .media_valid(pv[1]),
      .media_info(media_info), .busy_valid(pv[2]), .busy_event(busy_bits[31:24]),
      .busy_status(busy_bits[23:16]), .busy_time(busy_bits[15:0]), .blk_valid(blk_valid),
      .blk_ready(blk_ready), .blk_data(blk_data), .blk_addr(blk_addr));
   uesr_fifo_model u_fifo (.pclk(pclk), .presetn(presetn), .stall(stall), .blk_valid(blk_valid),
      .blk_data(blk_data), .blk_addr(blk_addr), .blk_ready(blk_ready), .got_blk(got_blk),
      .got_addr(got_addr), .got_n(got_n));
   // Expected blocks
   function automatic uesr_blk_type esn(input logic [7:0] q, input uesr_info_type v);
      return {8'h02, 8'h06, 8'h7f, q, v};
   endfunction : esn
   function automatic uesr_blk_type plain(input logic [7:0] key, input logic [7:0] code);
      return {8'h02, key, code, 8'h00, 32'h0};
   endfunction : plain
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One APB transfer, held until pready
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // One-cycle event pulse with payload on every class
   task ev(input int k, input uesr_info_type v);
      @(posedge pclk);
      pv <= 5'h01 << k;
      power_info <= v;
      media_info <= v;
      busy_bits <= v;
      defer_blk <= {32'h02031100, v};
      @(posedge pclk);
      pv <= 5'h00;
   endtask : ev
   task get;
      logic [15:0] n0;
      int k;
      n0 = got_n;
      for (k = 0; k < 40 && got_n === n0; k++) @(posedge pclk);
   endtask : get
   task arm_get;
      fork
         get;
         apb(1'b1, UESR_OFF_ENABLE, 32'h1);
      join
   endtask : arm_get
   task test_done;
      $display("tests=%0d errors=%0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done
   // Hang guard
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         test_done;
      end
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, UESR_OFF_STATUS, 32'h0);
      chk(rd, 32'h1);
      repeat (10) @(posedge pclk);
      chk(got_n, 16'h0);
      apb(1'b1, UESR_OFF_FIFO_LO, 32'h89abcdef);
      apb(1'b1, UESR_OFF_FIFO_HI, 32'h4567);
      arm_get;
      chk(got_blk, plain(8'h06, 8'h29));
      chk(got_addr, 48'h456789abcdef);
      // Three classes queued while not armed, sent in priority order
      ev(0, 32'h01020000);
      ev(2, 32'h01021234);
      ev(1, 32'h02000102);
      repeat (10) @(posedge pclk);
      chk(got_n, 16'h1);
      arm_get;
      chk(got_blk, esn(8'h06, 32'h01021234));
      arm_get;
      chk(got_blk, esn(8'h04, 32'h02000102));
      arm_get;
      chk(got_blk, esn(8'h02, 32'h01020000));
      // Every event code of the power and media classes
      for (i = 0; i < 4; i++) begin
         inf = {i[7:0], 8'h01 + i[7:0], 8'h01, 8'h02};
         ev(1, inf);
         arm_get;
         chk(got_blk, esn(8'h04, inf));
         if (i < 3) begin
            inf = {i[7:0], 8'h01 + i[7:0], 16'h0000};
            ev(0, inf);
            arm_get;
            chk(got_blk, esn(8'h02, inf));
         end
      end
      @(posedge pclk);
      dev_ready <= 1'b0;
      arm_get;
      chk(got_blk, plain(8'h02, 8'h04));
      @(posedge pclk);
      dev_ready <= 1'b1;
      arm_get;
      chk(got_blk, plain(8'h06, 8'h28));
      ev(4, 32'h0);
      arm_get;
      chk(got_blk, plain(8'h06, 8'h29));
      // Initiator stalls while a deferred error is offered
      stall <= 1'b1;
      ev(3, 32'hdeadbeef);
      apb(1'b1, UESR_OFF_ENABLE, 32'h1);
      repeat (8) @(posedge pclk);
      stall <= 1'b0;
      get;
      chk(got_blk, {32'h02031100, 32'hdeadbeef});
      // Armed and idle: an event goes out at once
      apb(1'b1, UESR_OFF_ENABLE, 32'h1);
      ev(2, 32'h01030a0b);
      repeat (5) @(posedge pclk);
      chk(got_blk, esn(8'h06, 32'h01030a0b));
      apb(1'b0, UESR_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, UESR_OFF_SENT, 32'h0);
      chk(rd, 32'h10);
      chk(got_n, 16'h10);
      apb(1'b0, 8'h40, 32'h0);
      chk({perr, rd}, 33'h100000000);
      // Same class twice before arming: overrun flag, latest payload sent
      ev(1, 32'h01000101);
      ev(1, 32'h02000202);
      apb(1'b0, UESR_OFF_STATUS, 32'h0);
      chk(rd, 32'h2020);
      arm_get;
      chk(got_blk, esn(8'h04, 32'h02000202));
      apb(1'b0, UESR_OFF_LAST_SENSE, 32'h0);
      chk(rd, 32'h02067f04);
      apb(1'b1, UESR_OFF_STATUS, 32'h2000);
      apb(1'b0, UESR_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      test_done;
   end
endmodule : uesr_reporter_tb
`default_nettype wire
